/* shared/omr_pkg.sv */
// Purpose: Constants and types for the output mixer route/gain register bank
// Assumes: APB with 32-bit data, one aligned word per register
// Notes: Printed offsets include non-multiples of four, so they are register indexes
package omr_pkg;
  localparam int OMR_NUM_GAIN = 8;
  localparam logic [7:0] OMR_IDX_L2R_RCOM = 8'h45;
  localparam logic [7:0] OMR_IDX_PGR_RCOM = 8'h46;
  localparam logic [7:0] OMR_IDX_DAR_RCOM = 8'h47;
  localparam logic [7:0] OMR_IDX_RCOM_LVL = 8'h48;
  localparam logic [7:0] OMR_IDX_L2L_MONO = 8'h49;
  localparam logic [7:0] OMR_IDX_PGL_MONO = 8'h4a;
  localparam logic [7:0] OMR_IDX_DAL_MONO = 8'h4b;
  localparam logic [7:0] OMR_IDX_L2R_MONO = 8'h4c;
  localparam logic [7:0] OMR_IDX_PGR_MONO = 8'h4d;
  // Field positions
  localparam int OMR_ROUTE_BIT = 7;
  localparam int OMR_VOL_MSB = 6;
  localparam int OMR_LVL_MSB = 7;
  localparam int OMR_LVL_LSB = 4;
  localparam int OMR_MUTE_BIT = 3;
  localparam int OMR_PDHZ_BIT = 2;
  localparam int OMR_PEND_BIT = 1;
  localparam int OMR_PWR_BIT = 0;
  // Reset values
  localparam logic [7:0] OMR_GAIN_RST = 8'h00;
  localparam logic [7:0] OMR_LVL_RST = 8'h06;
  localparam logic [3:0] OMR_LVL_MAX = 4'h9;
  // Settling time of the analog gain ramp
  localparam int OMR_SETTLE_NS = 1000;
  localparam int OMR_CLK_NS = 40;
  localparam int OMR_SETTLE_CYC = OMR_SETTLE_NS / OMR_CLK_NS;
  localparam logic [7:0] OMR_SETTLE_CNT = 8'(OMR_SETTLE_CYC);
  typedef enum logic [1:0] {
    OMR_ST_IDLE = 2'b01,
    OMR_ST_RAMP = 2'b10
  } omr_settle_t;
endpackage

/* shared/omr_wr_if.sv */
// Purpose: Carries a decoded register write between bank modules
// Assumes: Single clock domain
// Notes: Strobe is one cycle wide
`timescale 1ns/100ps
`default_nettype none
interface omr_wr_if;
  logic wr;
  logic [7:0] idx;
  logic [7:0] data;
  modport src (output wr, output idx, output data);
  modport dst (input wr, input idx, input data);
endinterface
`default_nettype wire

/* verilog/omr_gain_reg.sv */
// Purpose: One route-enable plus 7-bit volume register
// Assumes: Write strobe from the APB slave
// Notes: Value reaches the analog mixer controls through one more flop in omr_regs
`timescale 1ns/100ps
`default_nettype none
module omr_gain_reg
  import omr_pkg::*;
#(
  parameter logic [7:0] IDX = 8'h45
) (
  input wire logic clk,
  input wire logic rst_b,
  omr_wr_if.dst wr_bus,
  output logic [7:0] val,
  output logic changed
);
  logic [7:0] val_reg;
  logic [7:0] val_next;
  logic hit;
  always_comb begin
    hit = wr_bus.wr && (wr_bus.idx == IDX);
    val_next = hit ? wr_bus.data : val_reg;
  end
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      val_reg <= OMR_GAIN_RST;
    end else begin
      val_reg <= val_next;
    end
  end
  assign val = val_reg;
  assign changed = hit && (wr_bus.data != val_reg);
endmodule
`default_nettype wire

/* verilog/omr_settle.sv */
// Purpose: Tracks whether programmed gains have reached the analog path
// Assumes: Fixed ramp time after each change
// Notes: A new change restarts the ramp
`timescale 1ns/100ps
`default_nettype none
module omr_settle
  import omr_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic change,
  output logic pending
);
  omr_settle_t st_reg;
  omr_settle_t st_next;
  logic [7:0] cnt_reg;
  logic [7:0] cnt_next;
  always_comb begin
    st_next = st_reg;
    cnt_next = cnt_reg;
    case (st_reg)
      OMR_ST_IDLE: begin
        if (change) begin
          st_next = OMR_ST_RAMP;
          cnt_next = OMR_SETTLE_CNT;
        end
      end
      OMR_ST_RAMP: begin
        if (change) begin
          cnt_next = OMR_SETTLE_CNT;
        end else if (cnt_reg <= 8'h01) begin
          st_next = OMR_ST_IDLE;
          cnt_next = 8'h00;
        end else begin
          cnt_next = cnt_reg - 8'h01;
        end
      end
      default: begin
        st_next = OMR_ST_RAMP;
        cnt_next = OMR_SETTLE_CNT;
      end
    endcase
  end
  // Out of reset the gains still ramp, so pending starts high
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      st_reg <= OMR_ST_RAMP;
      cnt_reg <= OMR_SETTLE_CNT;
    end else begin
      st_reg <= st_next;
      cnt_reg <= cnt_next;
    end
  end
  assign pending = (st_reg == OMR_ST_RAMP);
endmodule
`default_nettype wire

/* verilog/omr_regs.sv */
// Purpose: APB register bank for right common headphone and mono line mixers
// Assumes: APB slave, zero wait states, byte address = 4 x register index
// Notes: Unmapped addresses read zero and raise pslverr
`timescale 1ns/100ps
`default_nettype none
// Overview of operation
// RULE1: Right line2 to right common route bit
// RULE2: Each mixer register holds 7-bit volume
// RULE3: Right preamp to right common route bit
// RULE4: Right DAC to right common route bit
// RULE5: Level field, 1 dB steps, 0 to 9
// RULE6: Software never writes reserved level codes
// RULE7: Mute bit, zero mutes, resets muted
// RULE8: Powered-down drive select, resets high-impedance
// RULE9: Pending bit high until gains applied
// RULE10: Power bit fully powers output up
// RULE11: Left line2 to mono route bit
// RULE12: Left preamp to mono route bit
// RULE13: Left DAC to mono route bit
// RULE14: Right line2 to mono route bit
// RULE15: Right preamp to mono route bit
// RULE16: Status bit read-only, set on change
// RULE17: Stored codes go unchanged to analog controls
module omr_regs
  import omr_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic rcom_right_line2_input_route,
  output logic [6:0] rcom_right_line2_input_vol,
  output logic rcom_right_input_preamp_route,
  output logic [6:0] rcom_right_input_preamp_vol,
  output logic rcom_right_dac_output_route,
  output logic [6:0] rcom_right_dac_output_vol,
  output logic [3:0] rcom_level,
  output logic rcom_unmute,
  output logic rcom_pd_hiz,
  output logic rcom_power_up,
  output logic mono_left_line2_input_route,
  output logic [6:0] mono_left_line2_input_vol,
  output logic mono_left_input_preamp_route,
  output logic [6:0] mono_left_input_preamp_vol,
  output logic mono_left_dac_output_route,
  output logic [6:0] mono_left_dac_output_vol,
  output logic mono_right_line2_input_route,
  output logic [6:0] mono_right_line2_input_vol,
  output logic mono_right_input_preamp_route,
  output logic [6:0] mono_right_input_preamp_vol
);
  localparam logic [7:0] GAIN_IDX [OMR_NUM_GAIN] = '{
    OMR_IDX_L2R_RCOM, OMR_IDX_PGR_RCOM, OMR_IDX_DAR_RCOM, OMR_IDX_L2L_MONO,
    OMR_IDX_PGL_MONO, OMR_IDX_DAL_MONO, OMR_IDX_L2R_MONO, OMR_IDX_PGR_MONO
  };

  function automatic logic idx_mapped(input logic [7:0] idx);
    logic m;
    m = (idx >= OMR_IDX_L2R_RCOM) && (idx <= OMR_IDX_PGR_MONO);
    return m;
  endfunction

  omr_wr_if wr_bus();
  logic [7:0] gain_val [OMR_NUM_GAIN];
  logic [OMR_NUM_GAIN-1:0] gain_chg;
  logic lvl_chg;
  logic pending;
  logic [7:0] idx;
  logic word_ok;
  logic access;
  logic [7:0] lvl_reg;
  logic [7:0] lvl_next;
  logic [7:0] rd_byte;
  logic [31:0] prdata_reg;
  logic [31:0] prdata_next;
  logic pslverr_reg;
  logic pslverr_next;
  logic [7:0] out_reg [OMR_NUM_GAIN];
  logic [7:0] lvl_out_reg;

  // Index decode; misaligned or high addresses fall into the error path
  always_comb begin
    idx = paddr[9:2];
    word_ok = (paddr[1:0] == 2'b00) && (paddr[31:10] == 22'h0) && idx_mapped(paddr[9:2]);
    access = psel && penable;
  end

  // Setup-cycle writes are ignored; only the access phase commits
  assign wr_bus.wr = access && pwrite && word_ok && pstrb[0];
  assign wr_bus.idx = idx;
  assign wr_bus.data = pwdata[7:0];

  for (genvar g = 0; g < OMR_NUM_GAIN; g++) begin : g_gain
    omr_gain_reg #(
      .IDX(GAIN_IDX[g])
    ) u_gain (
      .clk(clk),
      .rst_b(rst_b),
      .wr_bus(wr_bus),
      .val(gain_val[g]),
      .changed(gain_chg[g])
    );
  end

  // Level register; status bit is not writable
  always_comb begin
    lvl_next = lvl_reg;
    lvl_chg = 1'b0;
    if (wr_bus.wr && (idx == OMR_IDX_RCOM_LVL)) begin
      lvl_next[OMR_LVL_MSB:OMR_LVL_LSB] = pwdata[OMR_LVL_MSB:OMR_LVL_LSB]; // RULE5
      lvl_next[OMR_MUTE_BIT] = pwdata[OMR_MUTE_BIT]; // RULE7
      lvl_next[OMR_PDHZ_BIT] = pwdata[OMR_PDHZ_BIT]; // RULE8
      lvl_next[OMR_PWR_BIT] = pwdata[OMR_PWR_BIT]; // RULE10
      lvl_next[OMR_PEND_BIT] = 1'b0; // RULE16
      // Reserved codes are software's duty; stored as written
      lvl_chg = (pwdata[OMR_LVL_MSB:OMR_LVL_LSB] != lvl_reg[OMR_LVL_MSB:OMR_LVL_LSB]); // RULE6
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      lvl_reg <= OMR_LVL_RST;
    end else begin
      lvl_reg <= lvl_next;
    end
  end

  // Any gain register or level change restarts the ramp
  omr_settle u_settle (
    .clk(clk),
    .rst_b(rst_b),
    .change((|gain_chg) || lvl_chg), // RULE16
    .pending(pending)
  );

  // Read mux
  always_comb begin
    rd_byte = 8'h00;
    for (int i = 0; i < OMR_NUM_GAIN; i++) begin
      if (idx == GAIN_IDX[i]) begin
        rd_byte = gain_val[i]; // RULE2
      end
    end
    if (idx == OMR_IDX_RCOM_LVL) begin
      rd_byte = lvl_reg;
      rd_byte[OMR_PEND_BIT] = pending; // RULE9
    end
    prdata_next = prdata_reg;
    pslverr_next = 1'b0;
    if (psel && !penable) begin
      prdata_next = (!pwrite && word_ok) ? {24'h0, rd_byte} : 32'h0;
      pslverr_next = !word_ok;
    end
  end

  // Answer registered in setup so pready can be a flop held high
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      prdata_reg <= 32'h0;
      pslverr_reg <= 1'b0;
    end else begin
      prdata_reg <= prdata_next;
      pslverr_reg <= pslverr_next;
    end
  end

  // Analog controls registered so every output leaves a flop
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      for (int i = 0; i < OMR_NUM_GAIN; i++) begin
        out_reg[i] <= OMR_GAIN_RST;
      end
      lvl_out_reg <= OMR_LVL_RST;
    end else begin
      for (int i = 0; i < OMR_NUM_GAIN; i++) begin
        out_reg[i] <= gain_val[i]; // RULE17
      end
      lvl_out_reg <= lvl_reg;
    end
  end

  logic pready_reg;
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      pready_reg <= 1'b0;
    end else begin
      pready_reg <= 1'b1;
    end
  end

  assign pready = pready_reg;
  assign prdata = prdata_reg;
  // Straight from its flop; only set by a setup cycle, so low in reset
  assign pslverr = pslverr_reg;

  assign rcom_right_line2_input_route = out_reg[0][OMR_ROUTE_BIT]; // RULE1
  assign rcom_right_line2_input_vol = out_reg[0][OMR_VOL_MSB:0];
  assign rcom_right_input_preamp_route = out_reg[1][OMR_ROUTE_BIT]; // RULE3
  assign rcom_right_input_preamp_vol = out_reg[1][OMR_VOL_MSB:0];
  assign rcom_right_dac_output_route = out_reg[2][OMR_ROUTE_BIT]; // RULE4
  assign rcom_right_dac_output_vol = out_reg[2][OMR_VOL_MSB:0];
  assign rcom_level = lvl_out_reg[OMR_LVL_MSB:OMR_LVL_LSB];
  assign rcom_unmute = lvl_out_reg[OMR_MUTE_BIT];
  assign rcom_pd_hiz = lvl_out_reg[OMR_PDHZ_BIT];
  assign rcom_power_up = lvl_out_reg[OMR_PWR_BIT];
  assign mono_left_line2_input_route = out_reg[3][OMR_ROUTE_BIT]; // RULE11
  assign mono_left_line2_input_vol = out_reg[3][OMR_VOL_MSB:0];
  assign mono_left_input_preamp_route = out_reg[4][OMR_ROUTE_BIT]; // RULE12
  assign mono_left_input_preamp_vol = out_reg[4][OMR_VOL_MSB:0];
  assign mono_left_dac_output_route = out_reg[5][OMR_ROUTE_BIT]; // RULE13
  assign mono_left_dac_output_vol = out_reg[5][OMR_VOL_MSB:0];
  assign mono_right_line2_input_route = out_reg[6][OMR_ROUTE_BIT]; // RULE14
  assign mono_right_line2_input_vol = out_reg[6][OMR_VOL_MSB:0];
  assign mono_right_input_preamp_route = out_reg[7][OMR_ROUTE_BIT]; // RULE15
  assign mono_right_input_preamp_vol = out_reg[7][OMR_VOL_MSB:0];
endmodule
`default_nettype wire

/* test/omr_regs_sva.sv */
// Purpose: Concurrent checks on the APB side and the mixer control outputs
// Assumes: Zero wait states after reset, outputs lag the register by one clock
// Notes: Sees only the top module's ports
`timescale 1ns/100ps
`default_nettype none
module omr_regs_sva
  import omr_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic rcom_right_line2_input_route,
  input wire logic [6:0] rcom_right_line2_input_vol,
  input wire logic [6:0] rcom_right_dac_output_vol,
  input wire logic [3:0] rcom_level,
  input wire logic rcom_unmute,
  input wire logic rcom_pd_hiz,
  input wire logic rcom_power_up,
  input wire logic mono_right_input_preamp_route,
  input wire logic [6:0] mono_right_input_preamp_vol
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  logic acc, good, wr_ok, wr_dar;
  logic [7:0] idx;
  assign acc = psel & penable & pready;
  assign idx = paddr[9:2];
  assign good = paddr[31:10] == 22'h0 && paddr[1:0] == 2'h0 && idx >= 8'h45 && idx <= 8'h4d;
  assign wr_ok = acc & pwrite & pstrb[0] & good;
  assign wr_dar = wr_ok && idx == OMR_IDX_DAR_RCOM;
  sequence s_wr(logic [7:0] i);
    wr_ok && idx == i;
  endsequence
  a_pready_up: assert property (rst_b && $past(rst_b) && $past(rst_b, 2) |-> pready)
    else $error("pready low after reset");
  a_route_l2r: assert property (s_wr(OMR_IDX_L2R_RCOM) |-> ##2
    {rcom_right_line2_input_route, rcom_right_line2_input_vol} == $past(pwdata[7:0], 2))
    else $error("right line2 route or volume wrong");
  a_mono_pgr: assert property (s_wr(OMR_IDX_PGR_MONO) |-> ##2
    {mono_right_input_preamp_route, mono_right_input_preamp_vol} == $past(pwdata[7:0], 2))
    else $error("mono preamp route or volume wrong");
  a_level_out: assert property (s_wr(OMR_IDX_RCOM_LVL) |-> ##2
    rcom_level == $past(pwdata[7:4], 2) && rcom_unmute == $past(pwdata[3], 2)
    && rcom_pd_hiz == $past(pwdata[2], 2) && rcom_power_up == $past(pwdata[0], 2))
    else $error("level register outputs wrong");
  a_dac_hold: assert property ($changed(rcom_right_dac_output_vol) |-> $past(wr_dar, 2))
    else $error("dac volume changed without a write");
  a_bad_err: assert property (acc && !good |-> pslverr)
    else $error("no error on unmapped access");
  a_good_ok: assert property (acc && good |-> !pslverr)
    else $error("error on mapped access");
  a_rd_upper: assert property (acc && !pwrite |-> prdata[31:8] == 24'h0
    && (good || prdata == 32'h0))
    else $error("read data upper bits or unmapped data nonzero");
endmodule
bind omr_regs omr_regs_sva chk (.*);
`default_nettype wire

/* test/omr_regs_tb.sv */
// Purpose: Self-checking bench for the mixer register bank
// Assumes: Zero wait states, byte address is four times the index
// Notes: Read results are checked by a separate monitor
`timescale 1ns/100ps
`default_nettype none
module omr_regs_tb
  import omr_pkg::*;
;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr;
  logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata;
  logic [3:0] pstrb = 4'hf;
  logic rcom_right_line2_input_route, rcom_right_input_preamp_route, rcom_right_dac_output_route;
  logic rcom_unmute, rcom_pd_hiz, rcom_power_up, mono_right_line2_input_route;
  logic mono_left_line2_input_route, mono_left_input_preamp_route, mono_left_dac_output_route;
  logic mono_right_input_preamp_route;
  logic [3:0] rcom_level;
  logic [6:0] rcom_right_line2_input_vol, rcom_right_input_preamp_vol, rcom_right_dac_output_vol;
  logic [6:0] mono_left_line2_input_vol, mono_left_input_preamp_vol, mono_left_dac_output_vol;
  logic [6:0] mono_right_line2_input_vol, mono_right_input_preamp_vol;
  int num_errors = 0, comparisons = 0;
  logic [32:0] exp_q[$];
  logic [32:0] note;
  logic [7:0] shadow [9];
  always #20 clk = ~clk;
  omr_regs dut (.*);
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] seen);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask
  task automatic summarize();
    $display("comparisons %0d, mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // Holds the request until pready; the next call or idle releases it
  task automatic apb(input logic wr, input logic [31:0] a, input logic [7:0] d,
                     input logic [32:0] e);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {24'h0, d};
    exp_q.push_back(e);
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1 && n < 50) begin
      n++;
      @(posedge clk);
    end
  endtask
  function automatic logic [31:0] ba(input logic [7:0] i);
    return {22'h0, i, 2'b00};
  endfunction
  task automatic rd(input logic [7:0] i, input logic [7:0] v);
    apb(1'b0, ba(i), 8'h0, {25'h0, v});
  endtask
  task automatic wr(input logic [7:0] i, input logic [7:0] v);
    apb(1'b1, ba(i), v, 33'h0);
  endtask
  task automatic idle();
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  always @(posedge clk) begin
    if (psel && penable && pready) begin
      note = exp_q.size() > 0 ? exp_q.pop_front() : 33'h1_0000_0000;
      check("pslverr", {31'h0, note[32]}, {31'h0, pslverr});
      if (!pwrite) check("prdata", note[31:0], prdata);
    end
  end
  initial begin
    repeat (3000) @(posedge clk);
    num_errors++;
    summarize();
  end
  initial begin
    void'($urandom(32'h5c4e));
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    // Level register read early, while the reset ramp is still pending
    for (int i = 0; i < 9; i++) rd(8'h45 + 8'(i), i == 3 ? OMR_LVL_RST : 8'h00);
    idle();
    repeat (30) @(posedge clk);
    rd(OMR_IDX_RCOM_LVL, 8'h04);
    $display("test reset values done");
    for (int i = 0; i < 9; i++) begin
      shadow[i] = i == 3 ? 8'h99 : 8'($urandom);
      wr(8'h45 + 8'(i), shadow[i] | (i == 3 ? 8'h02 : 8'h00));
    end
    for (int i = 0; i < 9; i++) rd(8'h45 + 8'(i), shadow[i] | (i == 3 ? 8'h02 : 8'h00));
    idle();
    repeat (30) @(posedge clk);
    wr(OMR_IDX_RCOM_LVL, 8'h99);
    rd(OMR_IDX_RCOM_LVL, 8'h99);
    $display("test random routes and level done");
    pstrb <= 4'he;
    wr(OMR_IDX_L2R_RCOM, ~shadow[0]);
    pstrb <= 4'hf;
    rd(OMR_IDX_L2R_RCOM, shadow[0]);
    apb(1'b0, ba(8'h44), 8'h0, {1'b1, 32'h0});
    apb(1'b1, ba(8'h4e), 8'hff, {1'b1, 32'h0});
    apb(1'b0, ba(8'h45) | 32'h1, 8'h0, {1'b1, 32'h0});
    apb(1'b0, ba(8'h4d) | 32'h400, 8'h0, {1'b1, 32'h0});
    rd(OMR_IDX_PGR_MONO, shadow[8]);
    idle();
    repeat (2) @(posedge clk);
    check("leftover notes", 32'h0, exp_q.size());
    check("rcom line2", {24'h0, shadow[0]}, {24'h0, rcom_right_line2_input_route, rcom_right_line2_input_vol});
    check("rcom preamp", {24'h0, shadow[1]}, {24'h0, rcom_right_input_preamp_route, rcom_right_input_preamp_vol});
    check("rcom dac", {24'h0, shadow[2]}, {24'h0, rcom_right_dac_output_route, rcom_right_dac_output_vol});
    check("rcom level", {25'h0, shadow[3][7:2], shadow[3][0]}, {25'h0, rcom_level, rcom_unmute, rcom_pd_hiz, rcom_power_up});
    check("mono left line2", {24'h0, shadow[4]}, {24'h0, mono_left_line2_input_route, mono_left_line2_input_vol});
    check("mono left preamp", {24'h0, shadow[5]}, {24'h0, mono_left_input_preamp_route, mono_left_input_preamp_vol});
    check("mono left dac", {24'h0, shadow[6]}, {24'h0, mono_left_dac_output_route, mono_left_dac_output_vol});
    check("mono right line2", {24'h0, shadow[7]}, {24'h0, mono_right_line2_input_route, mono_right_line2_input_vol});
    check("mono right preamp", {24'h0, shadow[8]}, {24'h0, mono_right_input_preamp_route, mono_right_input_preamp_vol});
    $display("test refusals done");
    summarize();
  end
endmodule
`default_nettype wire
